// file: design/pxr_ext_pages.sv
// Summary of operation
// - Three-bit page selector, zero after reset
// - Four-bit port selector, ports zero to two
// - Port above two: writes ignored, reads zero
// - Reserved bits ignore writes, read zero
// - Pair A line state in status byte
// - Pair B line state, same encoding
// - Child bit: one child, zero parent
// - Connected bit reflects peer connection
// - Filtered bias detect bit
// - Writable port disable, reset from strap
// - Negotiated speed field at second address
// - Six-bit division code on identification page
// - Ten-bit product code, high and low
// - Major and minor silicon revision numbers
// - Division and product match test port codes
// - Port event on enabled port changes
module pxr_ext_pages
  import pxr_pkg::*;
#(
  parameter logic [23:0] VENDOR_ID = 24'h123456,
  parameter logic [5:0]  DIVISION  = 6'h15,
  parameter logic [9:0]  PRODUCT   = 10'h2a5,
  parameter logic [3:0]  REV_MAJOR = 4'h3,
  parameter logic [3:0]  REV_MINOR = 4'h0
)
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_rvalid_o,
  input  wire logic [5:0] pair_a_line_state_i,
  input  wire logic [5:0] pair_b_line_state_i,
  input  wire logic [2:0] port_child_i,
  input  wire logic [2:0] port_connected_i,
  input  wire logic [2:0] port_bias_i,
  input  wire logic [8:0] port_speed_i,
  input  wire logic [2:0] port_fault_set_i,
  input  wire logic [2:0] port_off_strap_i,
  output logic      [2:0] port_disabled_o,
  output logic            port_event_set_o,
  output logic      [5:0] jtag_division_o,
  output logic      [9:0] jtag_product_o
);

  // ************************************************************
  // Selector register
  // ************************************************************
  logic [2:0] page_reg, page_next;
  logic [3:0] port_reg, port_next;
  logic       port_ok;

  assign port_ok = (port_reg <= PORT_MAX);

  // The selector is kept outside the paged window so it is always writable.
  always_comb begin
    page_next = page_reg;
    port_next = port_reg;
    if (reg_wr_i && reg_addr_i == ADDR_SELECT) begin
      page_next = reg_wdata_i[SEL_PAGE_MSB:SEL_PAGE_LSB];
      port_next = reg_wdata_i[SEL_PORT_MSB:SEL_PORT_LSB];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      page_reg <= PAGE_RESET;
      port_reg <= PORT_RESET;
    end else begin
      page_reg <= page_next;
      port_reg <= port_next;
    end
  end

  // ************************************************************
  // Per-port control and event logic
  // ************************************************************
  logic [2:0] wr_stat;
  logic [2:0] wr_ctl;
  logic [2:0] dis;
  logic [2:0] int_en;
  logic [2:0] fault;
  logic [2:0] evt;
  logic       page_write;

  // Writes reach a port only on the status page with a legal port number.
  assign page_write = reg_wr_i && page_reg == PAGE_PORT_STATUS && port_ok;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      assign wr_stat[gi] = page_write && reg_addr_i == ADDR_EXT_0
                           && port_reg == 4'(gi);
      assign wr_ctl[gi]  = page_write && reg_addr_i == ADDR_EXT_1
                           && port_reg == 4'(gi);
      pxr_port_ctl u_port (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .strap_i     (port_off_strap_i[gi]),
        .wr_stat_i   (wr_stat[gi]),
        .wr_ctl_i    (wr_ctl[gi]),
        .wr_data_i   (reg_wdata_i),
        .con_i       (port_connected_i[gi]),
        .bias_i      (port_bias_i[gi]),
        .fault_set_i (port_fault_set_i[gi]),
        .dis_o       (dis[gi]),
        .int_en_o    (int_en[gi]),
        .fault_o     (fault[gi]),
        .event_o     (evt[gi])
      );
    end
  endgenerate

  assign port_disabled_o  = dis;
  assign port_event_set_o = |evt;

  // ************************************************************
  // Read path
  // ************************************************************
  logic [7:0] id_byte;
  logic [7:0] stat_byte;
  logic [1:0] sel;
  logic [7:0] rdata_reg, rdata_next;
  logic       rvalid_reg, rvalid_next;

  assign sel = port_reg[1:0];

  pxr_id_rom #(
    .VENDOR_ID (VENDOR_ID),
    .DIVISION  (DIVISION),
    .PRODUCT   (PRODUCT),
    .REV_MAJOR (REV_MAJOR),
    .REV_MINOR (REV_MINOR)
  ) u_id (
    .addr_i (reg_addr_i),
    .data_o (id_byte)
  );

  // Test port sees the very same constants as the identification page.
  assign jtag_division_o = DIVISION;
  assign jtag_product_o  = PRODUCT;

  // Status page byte for the selected port; unused bits stay zero.
  always_comb begin
    stat_byte = BYTE_ZERO;
    case (reg_addr_i)
      ADDR_EXT_0: begin
        stat_byte[ST_A_MSB:ST_A_LSB] = pair_a_line_state_i[2*sel +: 2];
        stat_byte[ST_B_MSB:ST_B_LSB] = pair_b_line_state_i[2*sel +: 2];
        stat_byte[ST_CHILD]          = port_child_i[sel];
        stat_byte[ST_CON]            = port_connected_i[sel];
        stat_byte[ST_BIAS]           = port_bias_i[sel];
        stat_byte[ST_DIS]            = dis[sel];
      end
      ADDR_EXT_1: begin
        stat_byte[CT_SPD_MSB:CT_SPD_LSB] = port_speed_i[3*sel +: 3];
        stat_byte[CT_INT_EN]             = int_en[sel];
        stat_byte[CT_FAULT]              = fault[sel];
      end
      default: stat_byte = BYTE_ZERO;
    endcase
  end

  // Read data is registered: one cycle after the request.
  always_comb begin
    rvalid_next = reg_rd_i;
    rdata_next  = rdata_reg;
    if (reg_rd_i) begin
      rdata_next = BYTE_ZERO;
      if (reg_addr_i == ADDR_SELECT) begin
        rdata_next[SEL_PAGE_MSB:SEL_PAGE_LSB] = page_reg;
        rdata_next[SEL_PORT_MSB:SEL_PORT_LSB] = port_reg;
      end else if (reg_addr_i >= ADDR_EXT_0 && port_ok) begin
        if (page_reg == PAGE_PORT_STATUS) begin
          rdata_next = stat_byte;
        end else if (page_reg == PAGE_PRODUCT_ID) begin
          rdata_next = id_byte;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg  <= BYTE_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata_o  = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;

endmodule

// file: common/pxr_pkg.sv
package pxr_pkg;

  // ************************************************************
  // Geometry and register addresses
  // ************************************************************
  localparam int          NUM_PORTS       = 3;
  localparam logic [3:0]  ADDR_SELECT     = 4'h7;
  localparam logic [3:0]  ADDR_EXT_0      = 4'h8;
  localparam logic [3:0]  ADDR_EXT_1      = 4'h9;
  localparam logic [3:0]  ADDR_VENDOR_HI  = 4'ha;
  localparam logic [3:0]  ADDR_VENDOR_MID = 4'hb;
  localparam logic [3:0]  ADDR_VENDOR_LO  = 4'hc;
  localparam logic [3:0]  ADDR_DIV_PROD   = 4'hd;
  localparam logic [3:0]  ADDR_PROD_LO    = 4'he;
  localparam logic [3:0]  ADDR_REVISION   = 4'hf;

  // ************************************************************
  // Page and port selector
  // ************************************************************
  localparam logic [2:0]  PAGE_PORT_STATUS = 3'h0;
  localparam logic [2:0]  PAGE_PRODUCT_ID  = 3'h1;
  localparam logic [2:0]  PAGE_RESET       = 3'h0;
  localparam logic [3:0]  PORT_RESET       = 4'h0;
  localparam logic [3:0]  PORT_MAX         = 4'h2;
  localparam int          SEL_PAGE_MSB     = 7;
  localparam int          SEL_PAGE_LSB     = 5;
  localparam int          SEL_PORT_MSB     = 3;
  localparam int          SEL_PORT_LSB     = 0;

  // ************************************************************
  // Port status fields (column 0 is the data MSB)
  // ************************************************************
  localparam int          ST_A_MSB   = 7;
  localparam int          ST_A_LSB   = 6;
  localparam int          ST_B_MSB   = 5;
  localparam int          ST_B_LSB   = 4;
  localparam int          ST_CHILD   = 3;
  localparam int          ST_CON     = 2;
  localparam int          ST_BIAS    = 1;
  localparam int          ST_DIS     = 0;
  localparam int          CT_SPD_MSB = 7;
  localparam int          CT_SPD_LSB = 5;
  localparam int          CT_INT_EN  = 4;
  localparam int          CT_FAULT   = 3;

  // ************************************************************
  // Identification page contents
  // ************************************************************
  localparam logic [7:0]  COMPLIANCE_LEVEL = 8'h01;
  localparam int          ID_DIV_MSB       = 7;
  localparam int          ID_DIV_LSB       = 2;
  localparam int          ID_PRH_MSB       = 1;
  localparam int          ID_PRH_LSB       = 0;
  localparam int          ID_MAJ_MSB       = 7;
  localparam int          ID_MAJ_LSB       = 4;
  localparam int          ID_MIN_MSB       = 3;
  localparam int          ID_MIN_LSB       = 0;
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;

endpackage

// file: design/pxr_port_ctl.sv
module pxr_port_ctl
  import pxr_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       strap_i,
  input  wire logic       wr_stat_i,
  input  wire logic       wr_ctl_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       con_i,
  input  wire logic       bias_i,
  input  wire logic       fault_set_i,
  output logic            dis_o,
  output logic            int_en_o,
  output logic            fault_o,
  output logic            event_o
);

  logic       dis_reg,    dis_next;
  logic       int_en_reg, int_en_next;
  logic       fault_reg,  fault_next;
  logic       loaded_reg, loaded_next;
  logic [3:0] prev_reg,   prev_next;
  logic       event_reg,  event_next;
  logic [3:0] now_state;

  assign now_state = {con_i, bias_i, dis_reg, fault_reg};

  // Next-state logic. The strap is caught on the first edge after reset release, since an
  // asynchronous reset may only load constants.
  always_comb begin
    dis_next    = dis_reg;
    int_en_next = int_en_reg;
    fault_next  = fault_reg;
    loaded_next = 1'b1;
    prev_next   = now_state;
    event_next  = int_en_reg && (now_state != prev_reg);
    if (!loaded_reg) begin
      dis_next   = strap_i;
      event_next = 1'b0;
    end else if (wr_stat_i) begin
      dis_next = wr_data_i[ST_DIS];
    end
    if (wr_ctl_i) begin
      int_en_next = wr_data_i[CT_INT_EN];
      if (wr_data_i[CT_FAULT]) begin
        fault_next = 1'b0;
      end
    end
    // A fault arriving with a clear wins over the clear.
    if (fault_set_i) begin
      fault_next = 1'b1;
    end
  end

  // State registers.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dis_reg    <= 1'b0;
      int_en_reg <= 1'b0;
      fault_reg  <= 1'b0;
      loaded_reg <= 1'b0;
      prev_reg   <= 4'h0;
      event_reg  <= 1'b0;
    end else begin
      dis_reg    <= dis_next;
      int_en_reg <= int_en_next;
      fault_reg  <= fault_next;
      loaded_reg <= loaded_next;
      prev_reg   <= prev_next;
      event_reg  <= event_next;
    end
  end

  assign dis_o    = dis_reg;
  assign int_en_o = int_en_reg;
  assign fault_o  = fault_reg;
  assign event_o  = event_reg;

endmodule

// file: design/pxr_id_rom.sv
module pxr_id_rom
  import pxr_pkg::*;
#(
  parameter logic [23:0] VENDOR_ID  = 24'h123456,
  parameter logic [5:0]  DIVISION   = 6'h15,
  parameter logic [9:0]  PRODUCT    = 10'h2a5,
  parameter logic [3:0]  REV_MAJOR  = 4'h3,
  parameter logic [3:0]  REV_MINOR  = 4'h0
)
(
  input  wire logic [3:0] addr_i,
  output logic      [7:0] data_o
);

  // Identification bytes. Every default above is arbitrary and neutral.
  always_comb begin
    data_o = BYTE_ZERO;
    case (addr_i)
      ADDR_EXT_0:      data_o = COMPLIANCE_LEVEL;
      ADDR_VENDOR_HI:  data_o = VENDOR_ID[23:16];
      ADDR_VENDOR_MID: data_o = VENDOR_ID[15:8];
      ADDR_VENDOR_LO:  data_o = VENDOR_ID[7:0];
      ADDR_DIV_PROD: begin
        data_o[ID_DIV_MSB:ID_DIV_LSB] = DIVISION;
        data_o[ID_PRH_MSB:ID_PRH_LSB] = PRODUCT[9:8];
      end
      ADDR_PROD_LO:    data_o = PRODUCT[7:0];
      ADDR_REVISION: begin
        data_o[ID_MAJ_MSB:ID_MAJ_LSB] = REV_MAJOR;
        data_o[ID_MIN_MSB:ID_MIN_LSB] = REV_MINOR;
      end
      default:         data_o = BYTE_ZERO;
    endcase
  end

endmodule

// file: testbench/pxr_ext_pages_assertions.sv
module pxr_chk
  import pxr_pkg::*;
#(
  parameter logic [5:0] DIVISION = 6'h15,
  parameter logic [9:0] PRODUCT  = 10'h2a5
)
(
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reg_rvalid_o,
  input wire logic [2:0] port_disabled_o,
  input wire logic [5:0] jtag_division_o,
  input wire logic [9:0] jtag_product_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Register access checks
  // ****************************************
  // One clock domain, so the checks share clock and reset.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // A selector write, an idle slot, then a lone read of one address.
  sequence s_sel;
    reg_wr_i && reg_addr_i == ADDR_SELECT;
  endsequence
  sequence s_rd(logic [3:0] a);
    !reg_wr_i ##1 reg_rd_i && !reg_wr_i && reg_addr_i == a;
  endsequence

  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no answer");
  a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i)) else $error("stray answer");
  a_rdata_holds: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o)) else $error("data moved");
  a_sel_readback: assert property (
    s_sel ##1 s_rd(ADDR_SELECT) |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'hef))
    else $error("selector readback");
  a_high_port: assert property (
    (s_sel ##0 reg_wdata_i[3:0] > PORT_MAX && reg_wdata_i[7:5] == PAGE_PORT_STATUS)
    ##1 s_rd(ADDR_EXT_0) |=> reg_rdata_o == BYTE_ZERO) else $error("high port read");
  a_compliance_one: assert property (
    (s_sel ##0 reg_wdata_i[3:0] <= PORT_MAX && reg_wdata_i[7:5] == PAGE_PRODUCT_ID)
    ##1 s_rd(ADDR_EXT_0) |=> reg_rdata_o == COMPLIANCE_LEVEL) else $error("compliance");
  // The strap is loaded on the first edge after release, so it shows one edge later still.
  a_dis_cause: assert property (
    $changed(port_disabled_o) |-> $past(reg_wr_i) || $past(rst_i, 2))
    else $error("disable moved");
  a_jtag_div: assert property (jtag_division_o == DIVISION) else $error("division");
  a_jtag_prod: assert property (jtag_product_o == PRODUCT) else $error("product");
endmodule

bind pxr_ext_pages pxr_chk #(.DIVISION(DIVISION), .PRODUCT(PRODUCT)) i_chk (.*);

// file: testbench/pxr_link_model.sv
module pxr_link_model (
  input  wire logic       ref_clk_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [3:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Link side register requests
  // ****************************************
  // Idle at time zero.
  initial begin
    {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = '0;
  end

  // One request for one edge; released lines flip so stale values never pass.
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1 {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {w, !w, a, d};
    @(posedge ref_clk_i);
    #1 {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {2'b00, ~a, ~d};
  endtask
endmodule

// file: testbench/tb_top.sv
module tb_top
  import pxr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // Identity values are arbitrary.
  localparam logic [23:0] VID = 24'h5a3c96;
  localparam logic [5:0]  DIV = 6'h2b;
  localparam logic [9:0]  PRD = 10'h1c7;
  logic       ref_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       wr_s, rd_s, rvalid, ev;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [5:0] pa = '0, pb = '0, jd;
  logic [2:0] ch = '0, con = '0, bias = '0, fs = '0, strap = '0, dis, dis_e;
  logic [8:0] spd = '0;
  logic [9:0] jp;
  logic [7:0] id [8];
  logic [7:0] exp_q [$];
  int         miscompares = 0, checked = 0;

  // ****************************************
  // Clock, design and link model
  // ****************************************
  always #2 ref_clk_i = ~ref_clk_i;

  pxr_ext_pages #(.VENDOR_ID(VID), .DIVISION(DIV), .PRODUCT(PRD), .REV_MAJOR(4'h2),
    .REV_MINOR(4'h1)) i_dut (.ref_clk_i, .rst_i, .reg_wr_i(wr_s), .reg_rd_i(rd_s),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .pair_a_line_state_i(pa), .pair_b_line_state_i(pb), .port_child_i(ch),
    .port_connected_i(con), .port_bias_i(bias), .port_speed_i(spd),
    .port_fault_set_i(fs), .port_off_strap_i(strap), .port_disabled_o(dis),
    .port_event_set_o(ev), .jtag_division_o(jd), .jtag_product_o(jp));

  pxr_link_model i_link (.ref_clk_i, .reg_wr_o(wr_s), .reg_rd_o(rd_s), .reg_addr_o(addr),
    .reg_wdata_o(wdata));

  task automatic cmp(input string n, input logic [9:0] e, input logic [9:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // The reader notes what it expects; the monitor below checks it.
  task automatic reg_read(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_link.xfer(1'b0, a, 8'h00);
  endtask

  task automatic sel(input logic [2:0] pg, input logic [3:0] pt);
    i_link.xfer(1'b1, ADDR_SELECT, {pg, 1'b0, pt});
  endtask

  function automatic logic [7:0] st(input int p);
    return {pa[2*p+:2], pb[2*p+:2], ch[p], con[p], bias[p], dis_e[p]};
  endfunction

  // A short wait is enough, the event pulse follows its cause within two edges.
  task automatic ev_wait(input logic e);
    logic got;
    got = 1'b0;
    repeat (8) begin
      @(posedge ref_clk_i);
      #1;
      if (ev === 1'b1) got = 1'b1;
    end
    cmp("event", e, got);
  endtask

  task automatic finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Each answer is checked at the falling edge of the cycle it stands, once it has settled.
  always @(negedge ref_clk_i) begin
    if (rvalid === 1'b1) cmp("rdata", exp_q.pop_front(), rdata);
  end

  // The whole run needs about 1 us.
  initial begin
    #20000 miscompares++;
    finish_test();
  end

  initial begin
    void'($urandom(32'h43df));
    strap = 3'($urandom);
    dis_e = strap;
    repeat (5) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    reg_read(ADDR_SELECT, 8'h00);
    cmp("disabled", strap, dis);
    i_link.xfer(1'b1, ADDR_SELECT, 8'hf5);
    reg_read(ADDR_SELECT, 8'he5);
    reg_read(ADDR_EXT_0, 8'h00);
    $display("test select done");
    {pa, pb, ch, con, bias} = 21'($urandom);
    for (int p = 0; p < NUM_PORTS; p++) spd[3*p+:3] = 3'($urandom % 3);
    for (int p = 0; p < NUM_PORTS; p++) begin
      sel(PAGE_PORT_STATUS, 4'(p));
      reg_read(ADDR_EXT_0, st(p));
      reg_read(ADDR_EXT_1, {spd[3*p+:3], 5'h00});
      for (int a = 10; a < 16; a++) reg_read(4'(a), 8'h00);
    end
    for (int p = 3; p < 16; p++) begin
      sel(PAGE_PORT_STATUS, 4'(p));
      reg_read(ADDR_EXT_0, 8'h00);
      i_link.xfer(1'b1, ADDR_EXT_0, 8'hff);
      reg_read(ADDR_SELECT, 8'(p));
    end
    cmp("disabled", dis_e, dis);
    sel(PAGE_PORT_STATUS, 4'h1);
    for (int v = 1; v >= 0; v--) begin
      i_link.xfer(1'b1, ADDR_EXT_0, {7'h7f, 1'(v)});
      dis_e[1] = 1'(v);
      reg_read(ADDR_EXT_0, st(1));
      cmp("disabled", dis_e, dis);
    end
    $display("test port status done");
    id = '{8'h01, 8'h00, VID[23:16], VID[15:8], VID[7:0], {DIV, PRD[9:8]}, PRD[7:0], 8'h21};
    sel(PAGE_PRODUCT_ID, 4'h0);
    for (int a = 0; a < 8; a++) reg_read(4'h8 + 4'(a), id[a]);
    i_link.xfer(1'b1, ADDR_DIV_PROD, 8'hff);
    reg_read(ADDR_DIV_PROD, id[5]);
    cmp("division", DIV, jd);
    cmp("product", PRD, jp);
    $display("test identification done");
    sel(PAGE_PORT_STATUS, 4'h0);
    i_link.xfer(1'b1, ADDR_EXT_1, 8'h10);
    con[0] = ~con[0];
    ev_wait(1'b1);
    con[2] = ~con[2];
    ev_wait(1'b0);
    fs = 3'h1;
    @(posedge ref_clk_i);
    #1 fs = 3'h0;
    reg_read(ADDR_EXT_1, {spd[2:0], 5'h18});
    i_link.xfer(1'b1, ADDR_EXT_1, 8'h18);
    reg_read(ADDR_EXT_1, {spd[2:0], 5'h10});
    $display("test events done");
    repeat (3) @(posedge ref_clk_i);
    finish_test();
  end
endmodule
